/* File: src/mgc_regs.svh */
/*
  Constants of the mute, gain and calibration control block: register
  offsets, field positions, reset values and timing counts.
  Assumes a 100 MHz system clock and an 8-bit sub-address register port.
*/
`ifndef MGC_REGS_SVH
`define MGC_REGS_SVH

// ****************************************************************
// sub-addresses
// ****************************************************************
`define MGC_ADDR_MUTE_STATUS 8'h00
`define MGC_ADDR_CAL_RB_FIRST 8'h02
`define MGC_ADDR_CAL_RB_LAST 8'h09
`define MGC_ADDR_VOL_FIRST 8'h25
`define MGC_ADDR_VOL_LAST 8'h2A
`define MGC_ADDR_MUTE_CTRL 8'h2C
`define MGC_ADDR_CAL_SRC 8'h2F
`define MGC_ADDR_FAULT_CTRL 8'h3A
`define MGC_ADDR_PGC_CTRL 8'h3D
`define MGC_ADDR_POST_GAIN 8'h3E
`define MGC_ADDR_IRQ_STATUS 8'h3F
`define MGC_ADDR_IRQ_MASK 8'h40
`define MGC_ADDR_BANK_FIRST 8'h70

// ****************************************************************
// field positions
// ****************************************************************
`define MGC_BIT_HARD_MUTE 1
`define MGC_BIT_FAULT_AUTO_RELEASE 2
`define MGC_BIT_FAULT_LATCH_CLEAR 1
`define MGC_BIT_PGC_ENABLE 7
`define MGC_BIT_STAT_FAULT_MUTE 1
`define MGC_BIT_STAT_CAL_BUSY 2

// ****************************************************************
// reset values and volume thresholds
// ****************************************************************
`define MGC_RST_MUTE_CTRL 8'h02
`define MGC_RST_VOLUME 8'h00
`define MGC_RST_POST_GAIN 2'h2
`define MGC_VOL_FULL_MIN 8'hF4
`define MGC_VOL_HALF_MIN 8'hE8
`define MGC_VOL_QUARTER_MIN 8'hDC

// ****************************************************************
// timing: calibration step of 1 s per pre-gain level
// ****************************************************************
`define MGC_CLK_HZ 100000000
`define MGC_CAL_STEP_MS 1000
`define MGC_CAL_STEP_CYCLES ((`MGC_CLK_HZ / 1000) * `MGC_CAL_STEP_MS)

`endif

/* File: src/mgc_pkg.sv */
/*
  Types of the mute, gain and calibration control block.
  Assumes nothing of its surroundings.
*/
package mgc_pkg;

  // pre-gain levels, in order of decreasing gain
  typedef enum logic [1:0] {
    MGC_GAIN_FULL,
    MGC_GAIN_HALF,
    MGC_GAIN_QUARTER,
    MGC_GAIN_EIGHTH
  } mgc_pregain_type;

  // three-state reading of the fault pin
  typedef enum logic [1:0] {
    MGC_FAULT_RELEASED,
    MGC_FAULT_HIGH,
    MGC_FAULT_LOW
  } mgc_fault_level_type;

  // calibration sequencer states
  typedef enum logic [1:0] {
    MGC_CAL_IDLE,
    MGC_CAL_RUN,
    MGC_CAL_STORE
  } mgc_cal_state_type;

endpackage

/* File: src/mgc_fault_if.sv */
/*
  Carrier between the fault sampler and the control top: the digitised
  three-state level of the fault pin.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface mgc_fault_if;
  import mgc_pkg::*;
  mgc_fault_level_type level;
  logic asserted;
  modport source (output level, output asserted);
  modport sink (input level, input asserted);
endinterface

`default_nettype wire

/* File: src/mgc_fault_sampler.sv */
/*
  Fault pin sampler: synchronises the two rail comparators and decodes
  the three-state pin level.
  Assumes asynchronous comparator levels.
*/
`timescale 1ns/1ns
`default_nettype none

module mgc_fault_sampler
  import mgc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic fault_above_in,
  input wire logic fault_below_in,
  mgc_fault_if.source fault_port
);

  typedef struct packed {
    logic [1:0] sync_first;
    logic [1:0] sync_second;
    mgc_fault_level_type level;
  } mgc_sampler_state_type;

  mgc_sampler_state_type state;
  mgc_sampler_state_type next_state;

  // first stage feeds only the second stage; decode looks at the second
  always_comb begin
    next_state = state;
    next_state.sync_first = {fault_above_in, fault_below_in};
    next_state.sync_second = state.sync_first;
    unique case (state.sync_second)
      2'h2: next_state.level = MGC_FAULT_HIGH; // R19
      2'h1: next_state.level = MGC_FAULT_LOW; // R19
      2'h3: next_state.level = MGC_FAULT_HIGH; // both: treat as fault
      2'h0: next_state.level = MGC_FAULT_RELEASED; // R19
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state <= '{sync_first: 2'h0, sync_second: 2'h0, level: MGC_FAULT_RELEASED};
    end else begin
      state <= next_state;
    end
  end

  assign fault_port.level = state.level;
  assign fault_port.asserted = (state.level != MGC_FAULT_RELEASED); // R03

endmodule // mgc_fault_sampler

`default_nettype wire

/* File: src/mgc_control.sv */
/*
  Mute, gain and calibration control of an audio processor:
  register file, fault mute, offset calibration, pre-gain selection and
  calibration source selection.
  Assumes a host register port on the system clock and a power
  stage that follows the mute and mode outputs.
*/
// Overview of operation
// [R01] reset pin low restores defaults in sub-addresses 00h-6Fh and 80h-EFh
// [R02] sub-addresses 70h-7Fh and F0h-FFh keep contents through the reset pin
// [R03] fault pin at either supply extreme forces hard mute
// [R04] auto-release bit set: fault mute ends when fault pin is released
// [R05] auto-release clear: mute latched until release and clear bit rises
// [R06] hard mute bit falling from one to zero starts offset calibration
// [R07] calibration ends within 1 s, or 4 s with predictive gain
// [R08] ten-bit offset per channel, four per channel with predictive gain
// [R09] readback registers 02h-09h show the offsets in use, tracking pre-gain
// [R10] low-EMI input high selects linear class B output path
// [R11] predictive gain bit set: pre-gain follows channel volume registers; the code follows only the channel 0 register (25h)
// [R12] predictive gain off holds pre-gain at full gain
// [R13] volume thresholds F4h, E8h, DCh select full, half, quarter, eighth gain
// [R14] four post-gain settings, 0 dB nominal
// [R15] calibration source bit one selects bank, zero the automatic value
// [R16] host banks calibration values by mute, calibrate, copy, re-mute
// [R17] host changes post-gain only at one-eighth pre-gain
// [R18] host latches fault and keeps clocks in sync during calibration
// [R19] fault pin read as three states: high, low, released
`timescale 1ns/1ns
`default_nettype none
`include "mgc_regs.svh"

module mgc_control
  import mgc_pkg::*;
#(
  parameter int CHANNELS = 6,
  parameter int OFFSET_WIDTH = 10,
  parameter int CAL_STEP_CYCLES = `MGC_CAL_STEP_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic reset_pin_active_low_in,
  input wire logic fault_above_in,
  input wire logic fault_below_in,
  input wire logic low_emi_mode_input_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [CHANNELS*OFFSET_WIDTH-1:0] cal_measure_in,
  output logic [7:0] reg_rdata_out,
  output logic hard_mute_out,
  output logic linear_mode_out,
  output logic [1:0] pregain_out,
  output logic [1:0] post_gain_out,
  output logic cal_busy_out,
  output logic [CHANNELS*OFFSET_WIDTH-1:0] offset_out,
  output logic irq_out
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (CHANNELS < 1 || CHANNELS > 6) begin : g_bad_channels
    $error("channel count must be 1 to 6");
  end
  if (OFFSET_WIDTH != 10) begin : g_bad_width
    $error("offset width must be 10");
  end
  if (CAL_STEP_CYCLES < 2) begin : g_bad_step
    $error("calibration step must be at least 2 cycles");
  end

  localparam int LEVELS = 4;
  localparam int CW = 32;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [1:0] rst_pin_sync;
    logic rst_pin_prev;
    logic [7:0] mute_ctrl;
    logic [7:0] cal_src;
    logic [7:0] fault_ctrl;
    logic [7:0] pgc_ctrl;
    logic [1:0] post_gain;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [CHANNELS-1:0][7:0] volume;
    logic [CHANNELS-1:0][OFFSET_WIDTH-1:0] bank;
    logic [CHANNELS-1:0][LEVELS-1:0][OFFSET_WIDTH-1:0] auto_cal;
    logic fault_mute;
    logic clear_armed;
    mgc_cal_state_type cal_state;
    logic [CW-1:0] cal_count;
    logic [1:0] cal_level;
    logic [7:0] rdata;
    logic hard_mute;
    logic linear_mode;
    mgc_pregain_type pregain;
    logic [CHANNELS-1:0][OFFSET_WIDTH-1:0] offset;
    logic irq;
  } mgc_ctrl_state_type;

  mgc_ctrl_state_type state;
  mgc_ctrl_state_type next_state;

  mgc_fault_if fault_link ();

  mgc_fault_sampler u_fault_sampler (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .fault_above_in(fault_above_in),
    .fault_below_in(fault_below_in),
    .fault_port(fault_link.source)
  );

  // ****************************************************************
  // functions
  // ****************************************************************
  // volume to pre-gain level
  function automatic mgc_pregain_type vol_to_gain(input logic [7:0] vol);
    if (vol >= `MGC_VOL_FULL_MIN) begin
      return MGC_GAIN_FULL; // R13
    end else if (vol >= `MGC_VOL_HALF_MIN) begin
      return MGC_GAIN_HALF; // R13
    end else if (vol >= `MGC_VOL_QUARTER_MIN) begin
      return MGC_GAIN_QUARTER; // R13
    end else begin
      return MGC_GAIN_EIGHTH; // R13
    end
  endfunction

  // readback layout: 02h-04h, 06h, 08h and 09h hold high bytes, 05h and 07h pack low pairs
  function automatic logic [7:0] readback(input logic [6:0] a,
      input logic [CHANNELS-1:0][OFFSET_WIDTH-1:0] off);
    logic [5:0][9:0] v;
    v = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      v[c] = off[c];
    end
    unique case (a)
      7'h02: return v[0][9:2];
      7'h03: return v[1][9:2];
      7'h04: return v[2][9:2];
      7'h05: return {2'h0, v[2][1:0], v[1][1:0], v[0][1:0]};
      7'h06: return v[3][9:2];
      7'h07: return {v[5][1:0], v[4][1:0], v[3][1:0], 2'h0};
      7'h08: return v[4][9:2];
      7'h09: return v[5][9:2];
      default: return 8'h00;
    endcase
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  logic pin_reset;
  logic [6:0] wa;
  logic [7:0] events;
  mgc_pregain_type gain_now;
  logic [1:0] lvl;

  always_comb begin
    next_state = state;
    events = 8'h00;
    wa = reg_addr_in[6:0];
    lvl = 2'h0;
    // pin passes two flops; pin_reset reads only the level of the second
    next_state.rst_pin_sync = {state.rst_pin_sync[0], reset_pin_active_low_in};
    next_state.rst_pin_prev = state.rst_pin_sync[1];
    pin_reset = !state.rst_pin_sync[1];

    // register writes; the mirrored range aliases low addresses
    if (reg_write_in) begin
      case (wa)
        `MGC_ADDR_MUTE_CTRL: next_state.mute_ctrl = reg_wdata_in;
        `MGC_ADDR_CAL_SRC: next_state.cal_src = reg_wdata_in;
        `MGC_ADDR_FAULT_CTRL: next_state.fault_ctrl = reg_wdata_in;
        `MGC_ADDR_PGC_CTRL: next_state.pgc_ctrl = reg_wdata_in;
        `MGC_ADDR_POST_GAIN: next_state.post_gain = reg_wdata_in[1:0]; // R14
        `MGC_ADDR_IRQ_MASK: next_state.irq_mask = reg_wdata_in;
        `MGC_ADDR_IRQ_STATUS: next_state.irq_status = state.irq_status & ~reg_wdata_in;
        default: begin
        end
      endcase
      for (int c = 0; c < CHANNELS; c++) begin
        if (wa == `MGC_ADDR_VOL_FIRST + 7'(c)) begin
          next_state.volume[c] = reg_wdata_in;
        end
        // bank: two bytes per channel, high byte first
        if (wa == `MGC_ADDR_BANK_FIRST + 7'(2 * c)) begin
          next_state.bank[c][9:2] = reg_wdata_in;
        end
        if (wa == `MGC_ADDR_BANK_FIRST + 7'(2 * c + 1)) begin
          next_state.bank[c][1:0] = reg_wdata_in[1:0];
        end
      end
    end

    // fault mute: set on fault, release by mode
    if (fault_link.asserted) begin
      next_state.fault_mute = 1'b1; // R03
      next_state.clear_armed = 1'b0;
    end else if (state.fault_mute) begin
      if (state.fault_ctrl[`MGC_BIT_FAULT_AUTO_RELEASE]) begin
        next_state.fault_mute = 1'b0; // R04
      end else if (reg_write_in && wa == `MGC_ADDR_FAULT_CTRL) begin
        // only a rising edge of the clear bit while released frees the mute
        if (!state.fault_ctrl[`MGC_BIT_FAULT_LATCH_CLEAR] &&
            reg_wdata_in[`MGC_BIT_FAULT_LATCH_CLEAR]) begin
          next_state.fault_mute = 1'b0; // R05
        end
      end
    end
    if (fault_link.asserted && !state.fault_mute) begin
      events[`MGC_BIT_STAT_FAULT_MUTE] = 1'b1;
    end

    // calibration sequencer
    gain_now = state.pgc_ctrl[`MGC_BIT_PGC_ENABLE] ?
        vol_to_gain(state.volume[0]) : MGC_GAIN_FULL; // R11 R12
    unique case (state.cal_state)
      MGC_CAL_IDLE: begin
        if (reg_write_in && wa == `MGC_ADDR_MUTE_CTRL &&
            state.mute_ctrl[`MGC_BIT_HARD_MUTE] && !reg_wdata_in[`MGC_BIT_HARD_MUTE]) begin
          next_state.cal_state = MGC_CAL_RUN; // R06
          next_state.cal_count = '0;
          next_state.cal_level = 2'h0;
        end
      end
      MGC_CAL_RUN: begin
        // one step per pre-gain level: 1 s without, 4 s with prediction
        if (state.cal_count == CW'(CAL_STEP_CYCLES - 1)) begin
          next_state.cal_state = MGC_CAL_STORE; // R07
        end else begin
          next_state.cal_count = state.cal_count + 1'b1;
        end
      end
      MGC_CAL_STORE: begin
        lvl = state.pgc_ctrl[`MGC_BIT_PGC_ENABLE] ? state.cal_level : 2'h0;
        for (int c = 0; c < CHANNELS; c++) begin
          next_state.auto_cal[c][lvl] = cal_measure_in[c*OFFSET_WIDTH +: OFFSET_WIDTH]; // R08
        end
        next_state.cal_count = '0;
        if (!state.pgc_ctrl[`MGC_BIT_PGC_ENABLE] || state.cal_level == 2'h3) begin
          next_state.cal_state = MGC_CAL_IDLE; // R07
          events[`MGC_BIT_STAT_CAL_BUSY] = 1'b1;
        end else begin
          next_state.cal_level = state.cal_level + 2'h1;
          next_state.cal_state = MGC_CAL_RUN;
        end
      end
    endcase

    // offsets in use follow pre-gain and source bit
    for (int c = 0; c < CHANNELS; c++) begin
      next_state.offset[c] = state.cal_src[c] ? state.bank[c] : // R15
          state.auto_cal[c][gain_now]; // R09
    end

    // status: sticky set wins over write-one clear
    next_state.irq_status = next_state.irq_status | events;
    next_state.hard_mute = state.mute_ctrl[`MGC_BIT_HARD_MUTE] || state.fault_mute; // R03
    next_state.linear_mode = low_emi_mode_input_in; // R10
    next_state.pregain = gain_now;
    next_state.irq = |(state.irq_status & state.irq_mask);

    // read data in the cycle after the strobe
    next_state.rdata = 8'h00;
    if (reg_read_in) begin
      unique case (wa) inside
        [`MGC_ADDR_CAL_RB_FIRST:`MGC_ADDR_CAL_RB_LAST]:
          next_state.rdata = readback(wa, state.offset); // R09
        `MGC_ADDR_MUTE_STATUS:
          next_state.rdata = {4'h0, state.linear_mode, state.cal_state != MGC_CAL_IDLE,
              state.hard_mute, 1'b0};
        `MGC_ADDR_MUTE_CTRL: next_state.rdata = state.mute_ctrl;
        `MGC_ADDR_CAL_SRC: next_state.rdata = state.cal_src;
        `MGC_ADDR_FAULT_CTRL: next_state.rdata = state.fault_ctrl;
        `MGC_ADDR_PGC_CTRL: next_state.rdata = state.pgc_ctrl;
        `MGC_ADDR_POST_GAIN: next_state.rdata = {6'h00, state.post_gain};
        `MGC_ADDR_IRQ_STATUS: next_state.rdata = state.irq_status;
        `MGC_ADDR_IRQ_MASK: next_state.rdata = state.irq_mask;
        default: begin
          for (int c = 0; c < CHANNELS; c++) begin
            if (wa == `MGC_ADDR_VOL_FIRST + 7'(c)) begin
              next_state.rdata = state.volume[c];
            end
            if (wa == `MGC_ADDR_BANK_FIRST + 7'(2 * c)) begin
              next_state.rdata = state.bank[c][9:2];
            end
            if (wa == `MGC_ADDR_BANK_FIRST + 7'(2 * c + 1)) begin
              next_state.rdata = {6'h00, state.bank[c][1:0]};
            end
          end
        end
      endcase
    end

    // reset pin: non-retained registers to defaults, bank kept
    if (pin_reset) begin
      next_state.mute_ctrl = `MGC_RST_MUTE_CTRL; // R01
      next_state.cal_src = 8'h00; // R01
      next_state.fault_ctrl = 8'h00; // R01
      next_state.pgc_ctrl = 8'h00; // R01
      next_state.post_gain = `MGC_RST_POST_GAIN; // R01
      next_state.irq_mask = 8'h00; // R01
      next_state.irq_status = 8'h00; // R01
      next_state.volume = {CHANNELS{`MGC_RST_VOLUME}}; // R01
      next_state.cal_state = MGC_CAL_IDLE;
      // bank lives at retained sub-addresses and is not touched
      next_state.bank = state.bank; // R02
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state <= '0;
      state.rst_pin_sync <= 2'h3;
      state.rst_pin_prev <= 1'b1;
      state.mute_ctrl <= `MGC_RST_MUTE_CTRL;
      state.post_gain <= `MGC_RST_POST_GAIN;
      state.hard_mute <= 1'b1;
      state.cal_state <= MGC_CAL_IDLE;
      state.pregain <= MGC_GAIN_FULL;
    end else begin
      state <= next_state;
    end
  end

  // every output straight from a flop except cal_busy_out, decoded from cal_state
  assign reg_rdata_out = state.rdata;
  assign hard_mute_out = state.hard_mute;
  assign linear_mode_out = state.linear_mode;
  assign pregain_out = state.pregain;
  assign post_gain_out = state.post_gain;
  assign cal_busy_out = state.cal_state != MGC_CAL_IDLE;
  assign offset_out = state.offset;
  assign irq_out = state.irq;

endmodule // mgc_control

`default_nettype wire

/* File: sim/mgc_control_properties.sv */
/*
  Port checker of the mute, gain and calibration control block.
  Assumes it is bound to every mgc_control and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none

module mgc_control_properties
  import mgc_pkg::*;
#(
  parameter int CAL_STEP_CYCLES = 8
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic reset_pin_active_low_in,
  input wire logic fault_above_in,
  input wire logic fault_below_in,
  input wire logic low_emi_mode_input_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic hard_mute_out,
  input wire logic linear_mode_out,
  input wire logic [1:0] pregain_out,
  input wire logic cal_busy_out
);
  localparam int CAL_LIMIT = 4 * (CAL_STEP_CYCLES + 1);
  logic [6:0] wa;
  logic wmute;
  logic hm_sh;
  logic auto_sh;
  logic pgc_sh;
  logic [7:0] vol_sh;
  logic [2:0] quiet;
  logic [31:0] busy_cnt;
  logic [1:0] exp_gain;

  // ****
  // shadows of the control bits
  // ****
  assign wa = reg_addr_in[6:0]; // bit 7 only mirrors
  assign wmute = reg_write_in && (wa == 7'h2C || wa == 7'h3A);
  // expected pre-gain from shadowed volume
  always_comb begin
    if (!pgc_sh) begin
      exp_gain = 2'(MGC_GAIN_FULL);
    end else if (vol_sh >= 8'hF4) begin
      exp_gain = 2'(MGC_GAIN_FULL);
    end else if (vol_sh >= 8'hE8) begin
      exp_gain = 2'(MGC_GAIN_HALF);
    end else if (vol_sh >= 8'hDC) begin
      exp_gain = 2'(MGC_GAIN_QUARTER);
    end else begin
      exp_gain = 2'(MGC_GAIN_EIGHTH);
    end
  end
  // pin reset clears shadows at once; the design lags two cycles, hidden by quiet
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || !reset_pin_active_low_in) begin
      hm_sh <= 1'b1;
      auto_sh <= 1'b0;
      pgc_sh <= 1'b0;
      vol_sh <= 8'h00;
    end else if (reg_write_in) begin
      if (wa == 7'h2C) hm_sh <= reg_wdata_in[1];
      if (wa == 7'h3A) auto_sh <= reg_wdata_in[2];
      if (wa == 7'h3D) pgc_sh <= reg_wdata_in[7];
      if (wa == 7'h25) vol_sh <= reg_wdata_in;
    end
  end
  // cycles since pre-gain inputs last moved
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || !reset_pin_active_low_in || cal_busy_out ||
        (reg_write_in && (wa == 7'h25 || wa == 7'h3D))) begin
      quiet <= 3'h0;
    end else if (quiet != 3'h7) begin
      quiet <= quiet + 3'h1;
    end
  end
  // length of the running calibration
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || !cal_busy_out) begin
      busy_cnt <= 32'h0;
    end else begin
      busy_cnt <= busy_cnt + 32'h1;
    end
  end

  // ****
  // properties
  // ****
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  a_fault_forces_mute: assert property ((fault_above_in || fault_below_in) [*8] |-> hard_mute_out)
    else $error("fault without hard mute");
  a_auto_release: assert property ((!fault_above_in && !fault_below_in && auto_sh && !hm_sh) [*8]
    |-> !hard_mute_out)
    else $error("auto release failed");
  a_latched_mute: assert property (hard_mute_out && !auto_sh && !wmute && !$past(wmute)
    |=> hard_mute_out)
    else $error("latched mute ended");
  a_unmute_starts_cal: assert property (reg_write_in && wa == 7'h2C && !reg_wdata_in[1] && hm_sh
    |=> cal_busy_out)
    else $error("no calibration on unmute");
  a_cal_time_bound: assert property (cal_busy_out |-> busy_cnt < CAL_LIMIT)
    else $error("calibration too long");
  a_linear_follows: assert property (##1 linear_mode_out == $past(low_emi_mode_input_in))
    else $error("linear mode mismatch");
  a_pregain_map: assert property (quiet == 3'h7 |-> pregain_out == exp_gain)
    else $error("pre-gain mismatch");
  a_read_data_idle: assert property (!$past(reg_read_in) |-> reg_rdata_out == 8'h00)
    else $error("stray read data");

  c_cal_run: cover property ($rose(cal_busy_out));
  c_eighth_gain: cover property (pgc_sh && pregain_out == 2'(MGC_GAIN_EIGHTH));
  c_fault_mute: cover property (!hm_sh && $rose(hard_mute_out));
  c_linear_on: cover property ($rose(linear_mode_out));
endmodule // mgc_control_properties

bind mgc_control mgc_control_properties #(.CAL_STEP_CYCLES(CAL_STEP_CYCLES)) u_props (
  .sys_clk_in,
  .reset_in,
  .reset_pin_active_low_in,
  .fault_above_in,
  .fault_below_in,
  .low_emi_mode_input_in,
  .reg_addr_in,
  .reg_wdata_in,
  .reg_write_in,
  .reg_read_in,
  .reg_rdata_out,
  .hard_mute_out,
  .linear_mode_out,
  .pregain_out,
  .cal_busy_out
);

`default_nettype wire

/* File: sim/mgc_stage_model.sv */
/*
  Power stage and fault pin model: rail comparators and measured offsets.
  Assumes the bench commands the fault pin level.
*/
`timescale 1ns/1ns
`default_nettype none

module mgc_stage_model #(
  parameter int CHANNELS = 6,
  parameter int OFFSET_WIDTH = 10
) (
  input wire logic [1:0] fault_cmd_in,
  output logic fault_above_out,
  output logic fault_below_out,
  output logic [CHANNELS*OFFSET_WIDTH-1:0] cal_measure_out
);
  // 1 forces the upper rail, 2 the lower; otherwise the pin self-biases mid
  assign fault_above_out = (fault_cmd_in == 2'h1);
  assign fault_below_out = (fault_cmd_in == 2'h2);
  // offsets differ per channel so that packing slips show
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      cal_measure_out[c*OFFSET_WIDTH +: OFFSET_WIDTH] = OFFSET_WIDTH'(10'h2C5 + c);
    end
  end
endmodule // mgc_stage_model

`default_nettype wire

/* File: sim/mgc_control_test.sv */
/*
  Self-checking bench of the mute, gain and calibration control block.
  Assumes a short calibration step so the run stays brief.
*/
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module mgc_control_test;
  logic clk, rst, pin_n, emi, wr_stb, rd_stb, above, below, mute, lin, busy, irq;
  logic [7:0] addr, wdata, rdata, v;
  logic [1:0] pg, post, fcmd;
  logic [59:0] meas, offs;
  int n_fail, cmp_count, cycles, n;

  mgc_stage_model STAGE (.fault_cmd_in(fcmd), .fault_above_out(above),
    .fault_below_out(below), .cal_measure_out(meas));
  mgc_control #(.CAL_STEP_CYCLES(8)) DUT (.sys_clk_in(clk), .reset_in(rst),
    .reset_pin_active_low_in(pin_n), .fault_above_in(above), .fault_below_in(below),
    .low_emi_mode_input_in(emi), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_write_in(wr_stb), .reg_read_in(rd_stb), .cal_measure_in(meas),
    .reg_rdata_out(rdata), .hard_mute_out(mute), .linear_mode_out(lin),
    .pregain_out(pg), .post_gain_out(post), .cal_busy_out(busy),
    .offset_out(offs), .irq_out(irq));

  // ****
  // bus and helper tasks
  // ****
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr_stb <= 1'b1;
    @(posedge clk); wr_stb <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk); addr <= a; rd_stb <= 1'b1;
    @(posedge clk); rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  task chk_rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd(a, v);
    `CHK(nm, e, v)
  endtask
  task settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // counts busy cycles, bounded so a stuck sequencer cannot hang
  task wait_cal;
    n = 0;
    repeat (300) begin
      @(posedge clk); #1;
      if (busy === 1'b1) n++; else if (n > 0) break;
    end
    settle(1);
  endtask
  task stop_test;
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****
  // scenarios
  // ****
  task t_reset_post;
    chk_rd("mute_ctrl", 8'h2C, 8'h02);
    `CHK("post_rst", 2'h2, post)
    wr(8'h50, 8'hFF);
    chk_rd("unmapped", 8'h50, 8'h00);
    for (int g = 0; g < 4; g++) begin
      wr(8'h3E, 8'(g)); settle(2);
      `CHK("post_gain", 2'(g), post)
    end
  endtask
  task t_cal_irq;
    logic i1;
    wr(8'h3A, 8'h00);
    wr(8'h2C, 8'h00); wait_cal;
    `CHK("cal_len", 1'b1, n inside {[8:9]})
    `CHK("off_ch0", 10'h2C5, offs[9:0])
    `CHK("off_ch5", 10'h2CA, offs[59:50])
    chk_rd("readback", 8'h02, 8'hB1);
    rd(8'h3F, v); `CHK("cal_done", 1'b1, v[2])
    wr(8'h40, 8'h04); settle(2); i1 = irq;
    wr(8'h40, 8'h00); settle(2);
    `CHK("irq_mask", 2'h2, {i1, irq})
    wr(8'h3F, 8'h04); rd(8'h3F, v); settle(1);
    `CHK("irq_clr", 2'h0, {v[2], irq})
  endtask
  task t_fault;
    @(posedge clk) fcmd <= 2'h1; settle(8);
    `CHK("mute_high", 1'b1, mute)
    @(posedge clk) fcmd <= 2'h0; settle(8);
    `CHK("mute_latch", 1'b1, mute)
    wr(8'h3A, 8'h02); settle(2);
    `CHK("mute_clear", 1'b0, mute)
    wr(8'h3A, 8'h04);
    @(posedge clk) fcmd <= 2'h2; settle(8);
    `CHK("mute_low", 1'b1, mute)
    @(posedge clk) fcmd <= 2'h0; settle(8);
    `CHK("auto_rel", 1'b0, mute)
    wr(8'h3F, 8'h02);
  endtask
  task t_pgc;
    logic [7:0] vt[7] = '{8'hF4, 8'hF3, 8'hE8, 8'hE7, 8'hDC, 8'hDB, 8'hFF};
    logic [1:0] gt[7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
    wr(8'h3A, 8'h00); wr(8'h2C, 8'h02); wr(8'h3D, 8'h80); wr(8'h2C, 8'h00); wait_cal;
    `CHK("cal_pgc", 1'b1, n inside {[32:36]})
    settle(2); `CHK("gain_vol0", 2'h3, pg)
    for (int i = 0; i < 7; i++) begin
      wr(8'h25, vt[i]); settle(2);
      `CHK("gain_map", gt[i], pg)
    end
    wr(8'h3D, 8'h00); settle(2);
    `CHK("gain_off", 2'h0, pg)
  endtask
  task t_bank;
    wr(8'h2C, 8'h02); wr(8'h3E, 8'h00);
    for (int c = 0; c < 6; c++) wr(8'h25 + 8'(c), 8'h00);
    wr(8'h2C, 8'h00); wait_cal;
    wr(8'h70, 8'h55); wr(8'h71, 8'h02);
    wr(8'h2C, 8'h02); wr(8'h3E, 8'h03); wr(8'h2C, 8'h00); wait_cal;
    wr(8'h2F, 8'h01); settle(2);
    `CHK("bank_ch0", 10'h156, offs[9:0])
    `CHK("auto_ch5", 10'h2CA, offs[59:50])
    wr(8'h2F, 8'h00); settle(2);
    `CHK("auto_ch0", 10'h2C5, offs[9:0])
  endtask
  task t_pin_emi;
    @(posedge clk) pin_n <= 1'b0; emi <= 1'b1; settle(4);
    `CHK("linear_on", 1'b1, lin)
    @(posedge clk) pin_n <= 1'b1; emi <= 1'b0; settle(4);
    `CHK("linear_off", 1'b0, lin)
    chk_rd("bank_kept", 8'h70, 8'h55);
    chk_rd("bank_mirror", 8'hF0, 8'h55);
    chk_rd("mute_dflt", 8'hAC, 8'h02);
    `CHK("post_dflt", 2'h2, post)
  endtask

  // ****
  // clock, reset, sequence and timeout
  // ****
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    {rst, pin_n} = 2'b11;
    {emi, wr_stb, rd_stb, addr, wdata, fcmd} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset_post;
    t_cal_irq;
    t_fault;
    t_pgc;
    t_bank;
    t_pin_emi;
    stop_test;
  end
endmodule // mgc_control_test

`default_nettype wire
